// ---- inc/ssp_defines.svh ----
// constants for the serial module spi port
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH
`define SSP_MODE_M4      3'h0
`define SSP_MODE_M16     3'h1
`define SSP_MODE_M64     3'h2
`define SSP_MODE_MSUB    3'h3
`define SSP_MODE_MTMR    3'h4
`define SSP_MODE_SLAVE   3'h5
`define SSP_MODE_TWI     3'h6
`define SSP_MODE_OFF     3'h7
`define SSP_MODE_RESET   3'h7
`define SSP_DIV4_HALF    8'h02
`define SSP_DIV16_HALF   8'h08
`define SSP_DIV64_HALF   8'h20
`define SSP_BITS         4'h8
`endif

// ---- inc/ssp_pkg.sv ----
// types for the serial module spi port
package ssp_pkg;
	typedef struct packed {
		logic [2:0] mode;
		logic       enable;
		logic       lsb_first;
		logic       clk_idle_high;
		logic       rise_edge;
		logic       sel_enable;
	} ssp_cfg_type;

	typedef enum logic [2:0] {
		SSP_IDLE  = 3'b001,
		SSP_SHIFT = 3'b010,
		SSP_DONE  = 3'b100
	} ssp_state_type;
endpackage

// ---- core/ssp_buf2.sv ----
// two-entry valid/ready buffer
`timescale 1ns/100ps
`default_nettype none
module ssp_buf2 #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,      // clock
	input  wire logic             rst_b,    // async reset, low
	input  wire logic             in_valid, // write side valid
	output var  logic             in_ready, // room available
	input  wire logic [WIDTH-1:0] in_data,  // write data
	output var  logic             out_valid,// word available
	input  wire logic             out_ready,// reader takes
	output var  logic [WIDTH-1:0] out_data  // head word
);
	logic [WIDTH-1:0] mem [2];
	logic             wr_ptr;
	logic             rd_ptr;
	logic [1:0]       count;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	assign in_ready  = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end else begin
			wr_ptr <= wr_ptr ^ push;
			rd_ptr <= rd_ptr ^ pop;
			count  <= count + {1'b0, push} - {1'b0, pop};
		end
	end

	chk_buf_no_overflow: assert property (@(posedge clk) disable iff (!rst_b)
		count <= 2'h2)
		else $error("buffer count beyond two");
endmodule
`default_nettype wire

// ---- core/ssp_core.sv ----
// serial module spi port: master/slave shifter with pin control
//
// Summary of operation
// - one mode field picks spi or two-wire
// - pin-sharing selection routes serial functions
// - pull-ups allowed on enabled input pins
// - four lines, full duplex data
// - master starts transfers, drives clock
// - master or slave by configuration
// - selectable lsb or msb first
// - selectable rising or falling active edge in slave mode; master uses the edge leaving the clock idle level
// - select enable gives select, else float
// - module enable switches whole interface
// - pin state from mode and enables
// - mode field encodes dividers, slave, off
// - early select release sets incomplete, done
`timescale 1ns/100ps
`default_nettype none
`include "ssp_defines.svh"
module ssp_core
	import ssp_pkg::*;
#(
	parameter int DATA_BITS = 8
) (
	input  wire logic                 CLK,         // 40 mhz system clock
	input  wire logic                 RST_B,       // async reset, low
	input  wire logic [2:0]           SERIAL_MODE_SELECT, // operating mode field
	input  wire logic                 SERIAL_MODULE_ENABLE, // module enable
	input  wire logic                 LSB_FIRST,   // shift order
	input  wire logic                 CLK_IDLE_HIGH, // clock idle level
	input  wire logic                 RISE_EDGE,   // active edge select
	input  wire logic                 SELECT_PIN_ENABLE, // select pin function
	input  wire logic                 PIN_ROUTE,   // pin-sharing selection
	input  wire logic                 PULL_REQ,    // pull-high request
	input  wire logic                 SUB_TICK,    // sub clock tick
	input  wire logic                 TMR_TICK,    // timer match tick
	input  wire logic                 TX_VALID,    // tx word offered
	output var  logic                 TX_READY,    // tx word taken
	input  wire logic [DATA_BITS-1:0] TX_DATA,     // tx word
	output var  logic                 RX_VALID,    // rx word present
	input  wire logic                 RX_READY,    // rx word consumed
	output var  logic [DATA_BITS-1:0] RX_DATA,     // rx word
	input  wire logic                 CLEAR_DONE,  // clears done flag
	input  wire logic                 CLEAR_INCOMPLETE, // clears incomplete flag
	output logic                      TRANSFER_DONE_FLAG, // byte done, sticky
	output logic                      TRANSFER_INCOMPLETE_FLAG, // aborted, sticky
	output logic                      BUSY,        // shifting
	input  wire logic                 SERIAL_DATA_IN_LINE, // data in pin
	output logic                      SERIAL_DATA_OUT_LINE, // data out pin
	output logic                      SDO_OE,      // data out enable
	input  wire logic                 SCK_IN,      // clock pin input
	output logic                      SCK_OUT,     // clock pin output
	output logic                      SCK_OE,      // clock pin enable
	input  wire logic                 SLAVE_SELECT_LINE_IN_B, // select pin input
	output logic                      SLAVE_SELECT_LINE_OUT_B, // select pin output
	output logic                      SLAVE_SELECT_LINE_OE, // select pin enable
	output logic                      PULL_ENABLE  // pull-up allowed
);
	// ----------------------------------------------------------------
	// configuration decode
	// ----------------------------------------------------------------
	ssp_cfg_type cfg;
	assign cfg = '{mode: SERIAL_MODE_SELECT, enable: SERIAL_MODULE_ENABLE,
		lsb_first: LSB_FIRST, clk_idle_high: CLK_IDLE_HIGH,
		rise_edge: RISE_EDGE, sel_enable: SELECT_PIN_ENABLE};

	wire is_slave  = (cfg.mode == `SSP_MODE_SLAVE);
	wire is_master = (cfg.mode <= `SSP_MODE_MTMR);
	wire spi_on    = cfg.enable && PIN_ROUTE && (is_slave || is_master);
	wire sel_on    = spi_on && cfg.sel_enable;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] sck_sync;
	logic [1:0] sel_sync;
	logic [1:0] din_sync;
	logic       sck_prev;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			sck_sync <= 2'h0;
			sel_sync <= 2'h3;
			din_sync <= 2'h0;
			sck_prev <= 1'b0;
		end else begin
			sck_sync <= {sck_sync[0], SCK_IN};
			sel_sync <= {sel_sync[0], SLAVE_SELECT_LINE_IN_B};
			din_sync <= {din_sync[0], SERIAL_DATA_IN_LINE};
			sck_prev <= sck_sync[1];
		end
	end

	wire s_sck_rise = sck_sync[1] && !sck_prev;
	wire s_sck_fall = !sck_sync[1] && sck_prev;
	wire s_selected = !sel_sync[1] || !cfg.sel_enable;

	// ----------------------------------------------------------------
	// master clock generation
	// ----------------------------------------------------------------
	logic [7:0] div_cnt;
	logic       src_tick_prev;
	wire  [7:0] div_half = (cfg.mode == `SSP_MODE_M4)  ? `SSP_DIV4_HALF :
	                       (cfg.mode == `SSP_MODE_M16) ? `SSP_DIV16_HALF : `SSP_DIV64_HALF;
	wire        ext_src  = (cfg.mode == `SSP_MODE_MSUB) ? SUB_TICK : TMR_TICK;
	wire        use_ext  = (cfg.mode == `SSP_MODE_MSUB) || (cfg.mode == `SSP_MODE_MTMR);
	wire        div_hit  = (div_cnt == div_half - 8'h01);
	wire        m_toggle = use_ext ? (ext_src && !src_tick_prev) : div_hit;

	// ----------------------------------------------------------------
	// shift engine
	// ----------------------------------------------------------------
	ssp_state_type state;
	ssp_state_type next_state;
	logic [DATA_BITS-1:0] shreg;
	logic [3:0]           bit_cnt;
	logic                 m_phase;
	logic                 done_pulse;
	logic                 abort_pulse;

	wire buf_valid;
	wire buf_ready;
	wire [DATA_BITS-1:0] buf_data;

	// master takes each bit at the trailing toggle: the synced input then
	// still shows the pin as it stood at the active edge, even at /4
	wire m_edge      = (state == SSP_SHIFT) && is_master && m_toggle;
	wire m_sample    = m_edge && m_phase;
	wire s_active    = (state == SSP_SHIFT) && is_slave && s_selected &&
	                   (cfg.rise_edge ? s_sck_rise : s_sck_fall);
	wire do_sample   = m_sample || s_active;
	wire last_bit    = (bit_cnt == 4'(DATA_BITS - 1));
	wire early_lift  = is_slave && sel_on && sel_sync[1] && (state == SSP_SHIFT) &&
	                   (bit_cnt != 4'h0);
	wire start_ok    = spi_on && TX_VALID && buf_ready &&
	                   (is_master || s_selected);
	wire out_bit     = cfg.lsb_first ? shreg[0] : shreg[DATA_BITS-1];
	wire [DATA_BITS-1:0] shifted = cfg.lsb_first ?
		{din_sync[1], shreg[DATA_BITS-1:1]} : {shreg[DATA_BITS-2:0], din_sync[1]};

	always_comb begin
		next_state = state;
		case (state)
			SSP_IDLE: begin
				if (start_ok) begin
					next_state = SSP_SHIFT;
				end
			end
			SSP_SHIFT: begin
				if (!spi_on || early_lift) begin
					next_state = SSP_IDLE;
				end else if (do_sample && last_bit) begin
					next_state = SSP_DONE;
				end
			end
			SSP_DONE: begin
				next_state = SSP_IDLE;
			end
			default: begin
				next_state = SSP_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			state         <= SSP_IDLE;
			shreg         <= '0;
			bit_cnt       <= 4'h0;
			m_phase       <= 1'b0;
			div_cnt       <= 8'h00;
			src_tick_prev <= 1'b0;
		end else begin
			state         <= next_state;
			src_tick_prev <= ext_src;
			div_cnt       <= (div_hit || state != SSP_SHIFT) ? 8'h00 : div_cnt + 8'h01;
			if (state == SSP_IDLE && start_ok) begin
				shreg   <= TX_DATA;
				bit_cnt <= 4'h0;
				m_phase <= 1'b0;
			end else if (do_sample) begin
				shreg   <= shifted;
				bit_cnt <= bit_cnt + 4'h1;
			end
			if (m_edge) begin
				m_phase <= !m_phase;
			end
		end
	end

	wire tx_take = (state == SSP_IDLE) && start_ok;

	// ----------------------------------------------------------------
	// receive buffer
	// ----------------------------------------------------------------
	wire rx_push = (next_state == SSP_DONE) && (state == SSP_SHIFT);
	wire rx_out_valid;

	ssp_buf2 #(.WIDTH(DATA_BITS)) u_rx_buf (
		.clk       (CLK),
		.rst_b     (RST_B),
		.in_valid  (rx_push),
		.in_ready  (buf_ready),
		.in_data   (shifted),
		.out_valid (rx_out_valid),
		.out_ready (RX_READY && RX_VALID),
		.out_data  (buf_data)
	);
	assign buf_valid = rx_out_valid;

	// ----------------------------------------------------------------
	// flags and registered outputs
	// ----------------------------------------------------------------
	// first toggle always leaves the idle level, so no glitch at frame start
	wire m_clk_level = cfg.clk_idle_high ^ m_phase;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			TRANSFER_DONE_FLAG       <= 1'b0;
			TRANSFER_INCOMPLETE_FLAG <= 1'b0;
			BUSY                     <= 1'b0;
			TX_READY                 <= 1'b0;
			RX_VALID                 <= 1'b0;
			RX_DATA                  <= '0;
			SERIAL_DATA_OUT_LINE     <= 1'b0;
			SDO_OE                   <= 1'b0;
			SCK_OUT                  <= 1'b0;
			SCK_OE                   <= 1'b0;
			SLAVE_SELECT_LINE_OUT_B  <= 1'b1;
			SLAVE_SELECT_LINE_OE     <= 1'b0;
			PULL_ENABLE              <= 1'b0;
		end else begin
			// set wins over a simultaneous clear
			TRANSFER_DONE_FLAG       <= rx_push || early_lift ||
			                            (TRANSFER_DONE_FLAG && !CLEAR_DONE);
			TRANSFER_INCOMPLETE_FLAG <= early_lift ||
			                            (TRANSFER_INCOMPLETE_FLAG && !CLEAR_INCOMPLETE);
			BUSY                     <= (next_state == SSP_SHIFT);
			TX_READY                 <= tx_take;
			RX_VALID                 <= buf_valid && !(RX_READY && RX_VALID);
			RX_DATA                  <= buf_data;
			SERIAL_DATA_OUT_LINE     <= (next_state == SSP_SHIFT) ? out_bit : 1'b0;
			SDO_OE                   <= spi_on && (is_master || s_selected);
			SCK_OUT                  <= (state == SSP_SHIFT) ? m_clk_level : cfg.clk_idle_high;
			SCK_OE                   <= spi_on && is_master;
			SLAVE_SELECT_LINE_OUT_B  <= !(is_master && next_state == SSP_SHIFT);
			SLAVE_SELECT_LINE_OE     <= sel_on && is_master;
			PULL_ENABLE              <= spi_on && PULL_REQ;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_done_sticky: assert property (@(posedge CLK) disable iff (!RST_B)
		TRANSFER_DONE_FLAG && !CLEAR_DONE |=> TRANSFER_DONE_FLAG)
		else $error("done flag dropped without clear");
	chk_abort_flags: assert property (@(posedge CLK) disable iff (!RST_B)
		early_lift |=> TRANSFER_DONE_FLAG && TRANSFER_INCOMPLETE_FLAG)
		else $error("early release did not set both flags");
	chk_sck_slave: assert property (@(posedge CLK) disable iff (!RST_B)
		is_slave |=> !SCK_OE)
		else $error("slave drove the clock");
	chk_off_quiet: assert property (@(posedge CLK) disable iff (!RST_B)
		!cfg.enable |=> !SDO_OE && !SCK_OE && !SLAVE_SELECT_LINE_OE)
		else $error("disabled port drives pins");
	chk_sel_float: assert property (@(posedge CLK) disable iff (!RST_B)
		!cfg.sel_enable |=> !SLAVE_SELECT_LINE_OE)
		else $error("select pin driven while disabled");
	chk_done_after: assert property (@(posedge CLK) disable iff (!RST_B)
		rx_push |=> TRANSFER_DONE_FLAG ##1 !BUSY)
		else $error("byte end did not set done");
	chk_bits_bound: assert property (@(posedge CLK) disable iff (!RST_B)
		bit_cnt <= 4'(DATA_BITS))
		else $error("bit count overran");
	chk_busy_master: assert property (@(posedge CLK) disable iff (!RST_B)
		$rose(BUSY) && is_master |-> !SLAVE_SELECT_LINE_OUT_B)
		else $error("master shift without select low");
endmodule
`default_nettype wire

// ---- testbench/ssp_peer.sv ----
// external spi peripheral model: slave to a master port, master to a slave port
`timescale 1ns/100ps
`default_nettype none
module ssp_peer (
	input  wire logic sck_in,    // resolved clock line
	input  wire logic sel_in_b,  // resolved select line
	input  wire logic din,       // data from the port
	input  wire logic lsb,       // lsb first
	input  wire logic rise,      // rising edge active
	output var  logic dout,      // data to the port
	output var  logic sck_drv,   // clock while master
	output var  logic sel_drv_b, // select while master
	output var  logic mst        // drives clock and select
);
	logic [7:0] tx;
	logic [7:0] rx;
	logic [2:0] cnt;
	initial begin
		{dout, sck_drv, mst} = 3'h0;
		sel_drv_b = 1'b1;
		{tx, rx, cnt} = 19'h0;
	end
	always @(negedge sel_in_b) begin
		cnt = 3'h0;
		dout = lsb ? tx[0] : tx[7];
	end
	// released line shows the inverse so a stale sample cannot pass
	always @(posedge sel_in_b) dout = ~dout;
	always @(sck_in) if (sel_in_b === 1'b0) begin
		if (sck_in === rise) rx = lsb ? {din, rx[7:1]} : {rx[6:0], din};
		else begin
			cnt = cnt + 3'h1;
			dout = lsb ? tx[cnt] : tx[3'h7 - cnt];
		end
	end
	// single select line; clock stands still outside the frame
	task automatic run(input logic [7:0] b, input int n);
		tx = b;
		sck_drv = ~rise;
		mst = 1'b1;
		// odd offset keeps every link edge clear of the system clock edges
		#110 sel_drv_b = 1'b0;
		#400;
		repeat (n) begin
			#100 sck_drv = rise;
			#100 sck_drv = ~rise;
		end
		#100 sel_drv_b = 1'b1;
		#100 mst = 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- testbench/serial_module_spi_port_tb.sv ----
// self-checking bench for the spi port against the peer model
`timescale 1ns/100ps
`default_nettype none
`include "ssp_defines.svh"
module serial_module_spi_port_tb
	import ssp_pkg::*;
;
	ssp_cfg_type     cfg;
	logic            clk, rst_b, route, pull_req, txv, rxr, clrd, clri, sck_q, ok;
	logic [7:0]      txd, cyc;
	int              bad_count, cmp_count, hp, run_len, ntog, i;
	wire logic       tx_ready, rx_valid, done_f, inc_f, busy, so_line, so_oe, sck_o, sck_oe;
	wire logic       sel_o_b, sel_oe, pull_en, miso, p_sck, p_sel_b, p_mst, sck_w, sel_w;
	wire logic [7:0] rx_data;
	ssp_core dut (
		.CLK(clk), .RST_B(rst_b), .SERIAL_MODE_SELECT(cfg.mode), .SERIAL_MODULE_ENABLE(cfg.enable),
		.LSB_FIRST(cfg.lsb_first), .CLK_IDLE_HIGH(cfg.clk_idle_high), .RISE_EDGE(cfg.rise_edge),
		.SELECT_PIN_ENABLE(cfg.sel_enable), .PIN_ROUTE(route), .PULL_REQ(pull_req),
		.SUB_TICK(cyc[3]), .TMR_TICK(cyc[2]), .TX_VALID(txv), .TX_READY(tx_ready), .TX_DATA(txd),
		.RX_VALID(rx_valid), .RX_READY(rxr), .RX_DATA(rx_data), .CLEAR_DONE(clrd),
		.CLEAR_INCOMPLETE(clri), .TRANSFER_DONE_FLAG(done_f), .TRANSFER_INCOMPLETE_FLAG(inc_f),
		.BUSY(busy), .SERIAL_DATA_IN_LINE(miso), .SERIAL_DATA_OUT_LINE(so_line), .SDO_OE(so_oe),
		.SCK_IN(sck_w), .SCK_OUT(sck_o), .SCK_OE(sck_oe), .SLAVE_SELECT_LINE_IN_B(sel_w),
		.SLAVE_SELECT_LINE_OUT_B(sel_o_b), .SLAVE_SELECT_LINE_OE(sel_oe), .PULL_ENABLE(pull_en)
	);
	ssp_peer peer (
		.sck_in(sck_w), .sel_in_b(sel_w), .din(so_oe ? so_line : 1'b1), .lsb(cfg.lsb_first),
		.rise(cfg.rise_edge), .dout(miso), .sck_drv(p_sck), .sel_drv_b(p_sel_b), .mst(p_mst)
	);
	// undriven lines rest at their pulled level
	assign sck_w = sck_oe ? sck_o : p_mst ? p_sck : cfg.clk_idle_high;
	assign sel_w = sel_oe ? sel_o_b : p_mst ? p_sel_b : 1'b1;
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// tests need well under a millisecond
	initial begin
		#2000000;
		bad_count++;
		close_out();
	end
	// width of the second half period of each master frame
	always @(posedge clk) begin
		cyc <= cyc + 8'h01;
		sck_q <= sck_o;
		if (busy !== 1'b1) begin
			ntog <= 0;
			run_len <= 0;
		end else if (sck_o !== sck_q) begin
			ntog <= ntog + 1;
			run_len <= 0;
			if (ntog == 1) hp <= run_len + 1;
		end else run_len <= run_len + 1;
	end
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic clear;
		clrd <= 1'b1;
		clri <= 1'b1;
		tick(1);
		clrd <= 1'b0;
		clri <= 1'b0;
		tick(2);
		chk("done cleared", 8'(done_f), 8'h00);
		chk("incomplete cleared", 8'(inc_f), 8'h00);
	endtask
	task automatic send(input logic [7:0] b);
		txd <= b;
		txv <= 1'b1;
		ok = 1'b0;
		for (int k = 0; k < 40 && ok !== 1'b1; k++) begin
			@(posedge clk);
			ok = tx_ready;
		end
		txv <= 1'b0;
	endtask
	task automatic mxfer(input logic [7:0] b, input logic [7:0] r);
		peer.tx = r;
		send(b);
		chk("taken", 8'(ok), 8'h01);
		for (int k = 0; k < 1500 && done_f !== 1'b1; k++) @(posedge clk);
		tick(3);
		chk("peer received", peer.rx, b);
		chk("done set", 8'(done_f), 8'h01);
		clear();
	endtask
	task automatic pop(input logic [7:0] e);
		chk("rx valid", 8'(rx_valid), 8'h01);
		chk("rx data", rx_data, e);
		rxr <= 1'b1;
		tick(1);
		rxr <= 1'b0;
		tick(2);
	endtask
	initial begin
		cfg = '{`SSP_MODE_M4, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
		{route, pull_req} = 2'h3;
		{txv, rxr, clrd, clri, cyc, txd} = 20'h0;
		rst_b = 1'b0;
		tick(4);
		rst_b <= 1'b1;
		tick(3);
		chk("busy at reset", 8'(busy), 8'h00);
		chk("pull on", 8'(pull_en), 8'h01);
		for (i = 0; i < 5; i++) begin
			cfg.mode <= 3'(i);
			tick(3);
			mxfer(8'hA5 ^ 8'(i), 8'h3C + 8'(i));
			if (i < 3) chk("half period", 8'(hp), 8'h02 << (2 * i));
			pop(8'h3C + 8'(i));
		end
		cfg <= '{`SSP_MODE_M4, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
		tick(3);
		chk("idle high", 8'(sck_o), 8'h01);
		mxfer(8'h1E, 8'hC4);
		pop(8'hC4);
		// fill the receive buffer while the reader stalls
		mxfer(8'h11, 8'h22);
		mxfer(8'h33, 8'h44);
		send(8'h55);
		chk("refused when full", 8'(ok), 8'h00);
		pop(8'h22);
		pop(8'h44);
		chk("drained", 8'(rx_valid), 8'h00);
		cfg.sel_enable <= 1'b0;
		tick(3);
		chk("select released", 8'(sel_oe), 8'h00);
		cfg.sel_enable <= 1'b1;
		tick(3);
		chk("select driven", 8'(sel_oe), 8'h01);
		for (i = 0; i < 4; i++) begin
			cfg.enable <= (i != 0);
			cfg.mode <= (i == 1) ? `SSP_MODE_OFF : (i == 2) ? `SSP_MODE_TWI : `SSP_MODE_M4;
			route <= (i != 3);
			tick(3);
			chk("pull off", 8'(pull_en), 8'h00);
			send(8'h5A);
			chk("refused", 8'(ok), 8'h00);
			if (i == 0) chk("clock released", 8'(sck_oe), 8'h00);
		end
		cfg <= '{`SSP_MODE_SLAVE, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
		route <= 1'b1;
		tick(3);
		chk("slave clock released", 8'(sck_oe), 8'h00);
		fork
			peer.run(8'h96, 8);
			send(8'h69);
		join
		tick(4);
		chk("slave taken", 8'(ok), 8'h01);
		chk("peer got", peer.rx, 8'h69);
		chk("slave done", 8'(done_f), 8'h01);
		clear();
		pop(8'h96);
		fork
			peer.run(8'hF0, 3);
			send(8'h0F);
		join
		tick(4);
		chk("incomplete set", 8'(inc_f), 8'h01);
		chk("abort done set", 8'(done_f), 8'h01);
		clear();
		close_out();
	end
endmodule
`default_nettype wire
